// File: shared/dhp_pkg.sv
package dhp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;                    // Register select width
  localparam int DATA_W = 8;                    // Host data width

  // ----------------------------------------------------------------
  // Alternate function register fields and reset
  // ----------------------------------------------------------------
  localparam logic [2:0] ALT_FUNC_ADDR     = 3'h2;   // Alternate function register select
  localparam int         ALT_BCAST_BIT     = 0;      // Broadcast-write enable bit
  localparam logic [7:0] ALT_FUNC_RST      = 8'h00;  // Reset value
  localparam logic [7:0] DATA_IDLE         = 8'h00;  // Reset value of latched read and write bytes

  // ----------------------------------------------------------------
  // Strobe phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DHP_IDLE,                                   // No access in progress
    DHP_READ,                                   // Read strobe low
    DHP_WRITE                                   // Write strobe low
  } dhp_phase_t;

endpackage

// File: logic/dhp_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of pin inputs
module dhp_sync #(
  parameter int W   = 1,                        // Vector width
  parameter logic [W-1:0] INIT = '1             // Value held in reset
) (
  input  wire logic         i_clk,              // System clock
  input  wire logic         i_rst_n,            // Sync reset, active low
  input  wire logic [W-1:0] i_async,            // Pin levels
  output logic      [W-1:0] o_sync              // Synchronised levels
);

  logic [W-1:0] meta_q;                         // First stage, read only by second
  logic [W-1:0] meta_d;                         // First stage next
  logic [W-1:0] sync_q;                         // Second stage
  logic [W-1:0] sync_d;                         // Second stage next

  // Refuse an empty vector at elaboration
  if (W < 1) begin : g_w_chk
    $error("Synchroniser width must be at least one");
  end

  // Next values
  always_comb begin
    meta_d = i_rst_n ? i_async : INIT;
    sync_d = i_rst_n ? meta_q  : INIT;
  end

  // Registers
  always_ff @(posedge i_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign o_sync = sync_q;

endmodule

// File: logic/dhp_port.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Read strobe fall fetches, drives addressed byte
// R2 - Write strobe rise latches host data
// R3 - Accesses accepted only with chip select low
// R4 - Channel pick low is B, high A
// R5 - Broadcast bit writes both channels at once
// R6 - Channel A interrupt high on service request
// R7 - Channel B interrupt high on service request
// R8 - Per-channel active-low transmitter ready output
// R9 - Three address lines pick one of eight
// R10 - Eight-bit bidirectional host data bus
// R11 - Release data bus outside selected reads
module dhp_port (
  input  wire logic       I_SYS_CLK,            // System clock, 50 MHz
  input  wire logic       I_RST_N,              // Sync reset, active low
  input  wire logic       I_CHIP_SELECT_N,      // Chip select pin
  input  wire logic       I_CHANNEL_PICK,       // Channel pick pin, 1 = A
  input  wire logic       I_READ_STROBE_N,      // Read strobe pin
  input  wire logic       I_WRITE_STROBE_N,     // Write strobe pin
  input  wire logic [2:0] I_REGISTER_SELECT,    // Register select lines
  input  wire logic [7:0] I_HOST_DATA,          // Host data lines, input side
  output logic      [7:0] O_HOST_DATA,          // Host data lines, output side
  output logic            O_HOST_DATA_OE_N,     // Data drive enable, low drives
  input  wire logic [7:0] I_RD_DATA_A,          // Channel A register read data
  input  wire logic [7:0] I_RD_DATA_B,          // Channel B register read data
  input  wire logic [7:0] I_ALT_FUNC,           // Alternate function register value
  output logic            O_RD_STB_A,           // Channel A read pulse
  output logic            O_RD_STB_B,           // Channel B read pulse
  output logic            O_WR_STB_A,           // Channel A write pulse
  output logic            O_WR_STB_B,           // Channel B write pulse
  output logic      [2:0] O_REG_ADDR,           // Addressed register
  output logic      [7:0] O_WR_DATA,            // Latched write byte
  input  wire logic       I_SERVICE_A,          // Channel A service request
  input  wire logic       I_SERVICE_B,          // Channel B service request
  input  wire logic       I_TX_SPACE_A,         // Channel A transmit has space
  input  wire logic       I_TX_SPACE_B,         // Channel B transmit has space
  output logic            O_IRQ_CHANNEL_A,      // Channel A interrupt, active high
  output logic            O_IRQ_CHANNEL_B,      // Channel B interrupt, active high
  output logic            O_TX_READY_A_N,       // Channel A transmitter ready
  output logic            O_TX_READY_B_N        // Channel B transmitter ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 4 + dhp_pkg::ADDR_W + dhp_pkg::DATA_W;  // Synchronised width

  logic [SW-1:0] pins_s;                        // Synchronised pin vector
  logic          cs_n_s;                        // Chip select
  logic          pick_s;                        // Channel pick
  logic          rd_n_s;                        // Read strobe
  logic          wr_n_s;                        // Write strobe
  logic [2:0]    addr_s;                        // Register select
  logic [7:0]    data_s;                        // Host data

  dhp_sync #(
    .W    (SW),
    .INIT ({4'hF, {(SW-4){1'b0}}})
  ) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_async ({I_CHIP_SELECT_N, I_CHANNEL_PICK, I_READ_STROBE_N, I_WRITE_STROBE_N,
               I_REGISTER_SELECT, I_HOST_DATA}),
    .o_sync  (pins_s)
  );

  assign {cs_n_s, pick_s, rd_n_s, wr_n_s, addr_s, data_s} = pins_s;

  // ----------------------------------------------------------------
  // Access phase and latches
  // ----------------------------------------------------------------
  dhp_pkg::dhp_phase_t phase_q;                 // Current access phase
  dhp_pkg::dhp_phase_t phase_d;                 // Next phase
  logic       to_a_q, to_a_d;                   // Access targets channel A
  logic       to_b_q, to_b_d;                   // Access targets channel B
  logic [2:0] addr_q, addr_d;                   // Latched register select
  logic [7:0] wdat_q, wdat_d;                   // Latched write byte
  logic [7:0] rdat_q, rdat_d;                   // Read byte on the bus
  logic       oe_n_q, oe_n_d;                   // Bus drive enable, low drives
  logic       rd_a_q, rd_a_d;                   // Read pulse A
  logic       rd_b_q, rd_b_d;                   // Read pulse B
  logic       wr_a_q, wr_a_d;                   // Write pulse A
  logic       wr_b_q, wr_b_d;                   // Write pulse B
  logic       rd_n_p, wr_n_p;                   // Previous strobe levels
  logic       sel;                              // Chip selected
  logic       bcast;                            // Broadcast write enabled

  assign sel   = ~cs_n_s;                                        // R3
  assign bcast = I_ALT_FUNC[dhp_pkg::ALT_BCAST_BIT];             // R5

  // Next-state logic for accesses
  always_comb begin
    phase_d = phase_q;
    to_a_d  = to_a_q;
    to_b_d  = to_b_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    oe_n_d  = 1'b1;
    rd_a_d  = 1'b0;
    rd_b_d  = 1'b0;
    wr_a_d  = 1'b0;
    wr_b_d  = 1'b0;
    unique case (phase_q)
      dhp_pkg::DHP_IDLE: begin
        // Falling read strobe starts a read
        if (sel && rd_n_p && !rd_n_s) begin                      // R1
          phase_d = dhp_pkg::DHP_READ;
          to_a_d  = pick_s;                                      // R4
          to_b_d  = ~pick_s;                                     // R4
          addr_d  = addr_s;                                      // R9
          rd_a_d  = pick_s;
          rd_b_d  = ~pick_s;
          rdat_d  = pick_s ? I_RD_DATA_A : I_RD_DATA_B;
        end else if (sel && wr_n_p && !wr_n_s) begin             // R2
          // Falling write strobe starts a write
          phase_d = dhp_pkg::DHP_WRITE;
          to_a_d  = bcast | pick_s;                              // R5
          to_b_d  = bcast | ~pick_s;                             // R5
          addr_d  = addr_s;                                      // R9
        end
      end
      dhp_pkg::DHP_READ: begin
        // Keep the selected channel's read byte on the bus, refetched each cycle, until the strobe rises or select drops
        oe_n_d = 1'b0;                                           // R10
        rdat_d = to_a_q ? I_RD_DATA_A : I_RD_DATA_B;
        if (rd_n_s || !sel) begin                                // R11
          phase_d = dhp_pkg::DHP_IDLE;
          oe_n_d  = 1'b1;
        end
      end
      dhp_pkg::DHP_WRITE: begin
        // Track host data; commit on the rising edge
        wdat_d = data_s;
        if (wr_n_s) begin                                        // R2
          phase_d = dhp_pkg::DHP_IDLE;
          wr_a_d  = to_a_q;
          wr_b_d  = to_b_q;
          wdat_d  = wdat_q;
        end
      end
      default: phase_d = dhp_pkg::DHP_IDLE;
    endcase
    if (phase_q == dhp_pkg::DHP_IDLE && phase_d == dhp_pkg::DHP_READ) begin
      oe_n_d = 1'b0;
    end
  end

  // Registers for accesses
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      phase_q <= dhp_pkg::DHP_IDLE;
      to_a_q  <= 1'b0;
      to_b_q  <= 1'b0;
      addr_q  <= '0;
      wdat_q  <= dhp_pkg::DATA_IDLE;
      rdat_q  <= dhp_pkg::DATA_IDLE;
      oe_n_q  <= 1'b1;
      rd_a_q  <= 1'b0;
      rd_b_q  <= 1'b0;
      wr_a_q  <= 1'b0;
      wr_b_q  <= 1'b0;
      rd_n_p  <= 1'b1;
      wr_n_p  <= 1'b1;
    end else begin
      phase_q <= phase_d;
      to_a_q  <= to_a_d;
      to_b_q  <= to_b_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      oe_n_q  <= oe_n_d;
      rd_a_q  <= rd_a_d;
      rd_b_q  <= rd_b_d;
      wr_a_q  <= wr_a_d;
      wr_b_q  <= wr_b_d;
      rd_n_p  <= rd_n_s;
      wr_n_p  <= wr_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Channel status outputs
  // ----------------------------------------------------------------
  logic irq_a_q, irq_b_q;                       // Registered interrupts
  logic txr_a_n_q, txr_b_n_q;                   // Registered transmitter ready

  // Register the status outputs
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      irq_a_q   <= 1'b0;
      irq_b_q   <= 1'b0;
      txr_a_n_q <= 1'b1;
      txr_b_n_q <= 1'b1;
    end else begin
      irq_a_q   <= I_SERVICE_A;                                  // R6
      irq_b_q   <= I_SERVICE_B;                                  // R7
      txr_a_n_q <= ~I_TX_SPACE_A;                                // R8
      txr_b_n_q <= ~I_TX_SPACE_B;                                // R8
    end
  end

  assign O_HOST_DATA      = rdat_q;
  assign O_HOST_DATA_OE_N = oe_n_q;
  assign O_RD_STB_A       = rd_a_q;
  assign O_RD_STB_B       = rd_b_q;
  assign O_WR_STB_A       = wr_a_q;
  assign O_WR_STB_B       = wr_b_q;
  assign O_REG_ADDR       = addr_q;
  assign O_WR_DATA        = wdat_q;
  assign O_IRQ_CHANNEL_A  = irq_a_q;
  assign O_IRQ_CHANNEL_B  = irq_b_q;
  assign O_TX_READY_A_N   = txr_a_n_q;
  assign O_TX_READY_B_N   = txr_b_n_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rd_drive;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (phase_q == dhp_pkg::DHP_IDLE && sel && rd_n_p && !rd_n_s) |=> !O_HOST_DATA_OE_N;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("Read not driven"); // R1

  property p_wr_commit;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (phase_q == dhp_pkg::DHP_WRITE && wr_n_s) |=> (O_WR_STB_A || O_WR_STB_B);
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("Write not committed"); // R2

  property p_cs_gate;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (phase_q == dhp_pkg::DHP_IDLE && cs_n_s) |=> phase_q == dhp_pkg::DHP_IDLE;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("Access without select"); // R3

  property p_pick;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (phase_q == dhp_pkg::DHP_IDLE && sel && rd_n_p && !rd_n_s) |=> O_RD_STB_A == $past(pick_s);
  endproperty
  a_pick: assert property (p_pick) else $error("Wrong channel read"); // R4

  property p_bcast;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (phase_q == dhp_pkg::DHP_WRITE && wr_n_s && to_a_q && to_b_q) |=> O_WR_STB_A && O_WR_STB_B;
  endproperty
  a_bcast: assert property (p_bcast) else $error("Broadcast missed"); // R5

  property p_irq_a;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      $past(I_RST_N) |-> O_IRQ_CHANNEL_A == $past(I_SERVICE_A);
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("Irq A wrong"); // R6

  property p_irq_b;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      $past(I_RST_N) |-> O_IRQ_CHANNEL_B == $past(I_SERVICE_B);
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("Irq B wrong"); // R7

  property p_txr;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      $past(I_RST_N) |->
        (O_TX_READY_A_N != $past(I_TX_SPACE_A)) && (O_TX_READY_B_N != $past(I_TX_SPACE_B));
  endproperty
  a_txr: assert property (p_txr) else $error("Tx ready wrong"); // R8

  property p_release;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (phase_q != dhp_pkg::DHP_READ) |-> ##1 (O_HOST_DATA_OE_N || phase_q == dhp_pkg::DHP_READ);
  endproperty
  a_release: assert property (p_release) else $error("Bus driven idle"); // R11

  c_read_a: cover property (@(posedge I_SYS_CLK) O_RD_STB_A);
  c_read_b: cover property (@(posedge I_SYS_CLK) O_RD_STB_B);
  c_write_b: cover property (@(posedge I_SYS_CLK) O_WR_STB_B && !O_WR_STB_A);
  c_bcast: cover property (@(posedge I_SYS_CLK) O_WR_STB_A && O_WR_STB_B);

endmodule

// File: testbench/dhp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host processor model driving the register port pins
// ----------------------------------------------------------------
module dhp_host_model #(
  parameter int STB_LOW = 6                     // Strobe low cycles
) (
  input  wire logic       i_clk,                // System clock
  input  wire logic       i_go,                 // Start one access
  input  wire logic       i_wr,                 // 1 = write access
  input  wire logic       i_cs_n,               // Chip select level to use
  input  wire logic       i_pick,               // Channel pick level to use
  input  wire logic [2:0] i_addr,               // Register select to use
  input  wire logic [7:0] i_wdata,              // Byte to write
  input  wire logic [7:0] i_dev_data,           // Device read byte
  input  wire logic       i_dev_oe_n,           // Device drive enable, low drives
  output logic            o_cs_n,               // Chip select pin
  output logic            o_pick,               // Channel pick pin
  output logic            o_rd_n,               // Read strobe pin
  output logic            o_wr_n,               // Write strobe pin
  output logic      [2:0] o_addr,               // Register select pins
  output logic      [7:0] o_bus,                // Resolved data wire
  output logic      [7:0] o_rdata,              // Byte taken at read strobe rise
  output logic            o_done                // Access finished
);
  logic [7:0] host_val;                         // Host drive, or inverted once released

  // Wire level: device wins while it drives
  assign o_bus = (i_dev_oe_n === 1'b0) ? i_dev_data : host_val;

  // Idle pin levels
  initial begin
    o_cs_n   = 1'b1;
    o_pick   = 1'b0;
    o_rd_n   = 1'b1;
    o_wr_n   = 1'b1;
    o_addr   = 3'h0;
    o_rdata  = 8'h00;
    o_done   = 1'b1;
    host_val = 8'h96;
  end

  // One access for each go pulse
  initial forever begin
    @(posedge i_clk);
    if (i_go === 1'b1) begin
      o_done   <= 1'b0;
      o_cs_n   <= i_cs_n;
      o_pick   <= i_pick;
      o_addr   <= i_addr;
      host_val <= i_wr ? i_wdata : ~host_val;
      @(posedge i_clk);
      if (i_wr) begin
        o_wr_n <= 1'b0;
      end else begin
        o_rd_n <= 1'b0;
      end
      repeat (STB_LOW) @(posedge i_clk);
      o_rdata <= o_bus;
      o_rd_n  <= 1'b1;
      o_wr_n  <= 1'b1;
      // Data and select held past the synchronised rise
      repeat (3) @(posedge i_clk);
      o_cs_n   <= 1'b1;
      o_addr   <= ~o_addr;
      o_pick   <= ~o_pick;
      host_val <= ~host_val;
      repeat (4) @(posedge i_clk);
      o_done <= 1'b1;
    end
  end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       sys_clk, rst_n, h_go, h_wr, h_cs_n, h_pick, cs_n, pick, rd_n, wr_n, oe_n, done;
  logic       sva, svb, spa, spb, rsa, rsb, wsa, wsb, irqa, irqb, txa_n, txb_n;
  logic [2:0] h_addr, addr, reg_addr, ad_q;
  logic [7:0] h_wdata, bus, dout, rda, rdb, alt, wdat, wd_q, h_rdata;
  int         error_cnt, cmp_count;
  int         cnt[5] = '{default: 0};           // Pulse and drive cycle counts

  // Clock, 20 ns period
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  dhp_host_model u_host (.i_clk(sys_clk), .i_go(h_go), .i_wr(h_wr), .i_cs_n(h_cs_n),
    .i_pick(h_pick), .i_addr(h_addr), .i_wdata(h_wdata), .i_dev_data(dout),
    .i_dev_oe_n(oe_n), .o_cs_n(cs_n), .o_pick(pick), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_addr(addr), .o_bus(bus), .o_rdata(h_rdata), .o_done(done));

  dhp_port u_dut (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_CHIP_SELECT_N(cs_n),
    .I_CHANNEL_PICK(pick), .I_READ_STROBE_N(rd_n), .I_WRITE_STROBE_N(wr_n),
    .I_REGISTER_SELECT(addr), .I_HOST_DATA(bus), .O_HOST_DATA(dout), .O_HOST_DATA_OE_N(oe_n),
    .I_RD_DATA_A(rda), .I_RD_DATA_B(rdb), .I_ALT_FUNC(alt), .O_RD_STB_A(rsa),
    .O_RD_STB_B(rsb), .O_WR_STB_A(wsa), .O_WR_STB_B(wsb), .O_REG_ADDR(reg_addr),
    .O_WR_DATA(wdat), .I_SERVICE_A(sva), .I_SERVICE_B(svb), .I_TX_SPACE_A(spa),
    .I_TX_SPACE_B(spb), .O_IRQ_CHANNEL_A(irqa), .O_IRQ_CHANNEL_B(irqb),
    .O_TX_READY_A_N(txa_n), .O_TX_READY_B_N(txb_n));

  // Count pulses and drive cycles, keep last address and write byte
  always @(posedge sys_clk) begin
    cnt[0] <= cnt[0] + int'(rsa === 1'b1);
    cnt[1] <= cnt[1] + int'(rsb === 1'b1);
    cnt[2] <= cnt[2] + int'(wsa === 1'b1);
    cnt[3] <= cnt[3] + int'(wsb === 1'b1);
    cnt[4] <= cnt[4] + int'(oe_n === 1'b0);
    if ((rsa | rsb | wsa | wsb) === 1'b1) ad_q <= reg_addr;
    if ((wsa | wsb) === 1'b1) wd_q <= wdat;
  end

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // One host access, bounded wait for completion
  task automatic host_op(input logic wr, cs, pk, input logic [2:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    h_go    <= 1'b1;
    h_wr    <= wr;
    h_cs_n  <= cs;
    h_pick  <= pk;
    h_addr  <= a;
    h_wdata <= d;
    @(posedge sys_clk);
    h_go <= 1'b0;
    @(posedge sys_clk);
    k = 0;
    while (done !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 100) begin
      error_cnt++;
      $display("unexpected access completion: expected 1, seen timeout");
      wrap_up();
    end
    @(negedge sys_clk);
  endtask

  // Pulse counts since a snapshot
  task automatic cnt_chk(input int s[5], input int ra, rb, wa, wb, oe);
    chk("read_pulse_a", 8'(ra), 8'(cnt[0] - s[0]));
    chk("read_pulse_b", 8'(rb), 8'(cnt[1] - s[1]));
    chk("write_pulse_a", 8'(wa), 8'(cnt[2] - s[2]));
    chk("write_pulse_b", 8'(wb), 8'(cnt[3] - s[3]));
    chk("drive_cycles", 8'(oe), 8'(cnt[4] - s[4]));
  endtask

  task automatic t_reset();
    chk("oe_n", 8'h01, {7'h00, oe_n});
    chk("irq", 8'h00, {6'h00, irqa, irqb});
    chk("tx_ready_n", 8'h03, {6'h00, txa_n, txb_n});
  endtask

  task automatic t_read(input logic pk, input logic [2:0] a, input logic [7:0] exp);
    int s[5];
    s = cnt;
    host_op(1'b0, 1'b0, pk, a, 8'h00);
    chk("read_byte", exp, h_rdata);
    chk("reg_addr", {5'h00, a}, {5'h00, ad_q});
    chk("oe_n_after", 8'h01, {7'h00, oe_n});
    cnt_chk(s, int'(pk), int'(!pk), 0, 0, 6);
  endtask

  task automatic t_write(input logic pk, bc, input logic [2:0] a, input logic [7:0] d);
    int s[5];
    alt <= {7'h00, bc};
    s = cnt;
    host_op(1'b1, 1'b0, pk, a, d);
    chk("write_byte", d, wd_q);
    chk("reg_addr", {5'h00, a}, {5'h00, ad_q});
    cnt_chk(s, 0, 0, int'(bc | pk), int'(bc | !pk), 0);
  endtask

  task automatic t_nocs();
    int s[5];
    s = cnt;
    host_op(1'b0, 1'b1, 1'b1, 3'h1, 8'h00);
    host_op(1'b1, 1'b1, 1'b0, 3'h6, 8'h55);
    cnt_chk(s, 0, 0, 0, 0, 0);
  endtask

  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      sva <= i[0];
      svb <= i[1];
      spa <= i[1];
      spb <= i[0];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("irq_a", {7'h00, i[0]}, {7'h00, irqa});
      chk("irq_b", {7'h00, i[1]}, {7'h00, irqb});
      chk("tx_ready_n", {6'h00, ~i[1], ~i[0]}, {6'h00, txa_n, txb_n});
    end
  endtask

  initial begin
    {rst_n, h_go, h_wr, h_cs_n, h_pick, sva, svb, spa, spb} = 9'h000;
    {h_addr, h_wdata, alt} = 19'h0_0000;
    rda = 8'hA5;
    rdb = 8'h3C;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_read(1'b1, 3'h7, 8'hA5);
    t_read(1'b0, 3'h0, 8'h3C);
    t_write(1'b1, 1'b0, 3'h2, 8'h81);
    t_write(1'b0, 1'b0, 3'h5, 8'h7E);
    t_write(1'b1, 1'b1, 3'h3, 8'hC3);
    t_read(1'b0, 3'h4, 8'h3C);
    t_nocs();
    t_levels();
    wrap_up();
  end
endmodule
